// [bench/match_based_pwm_timer_tb.sv]
// Self-checking bench of the match based PWM timer
`include "mpt_map.svh"
module match_based_pwm_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] cap = 2'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:1] pwm;
  logic irq;
  logic [31:0] rv;
  logic [31:0] cv;
  logic re;
  int hi_len [6:1];
  int period [6:1];
  int rises [6:1];
  int n_errors = 0;
  int num_checks = 0;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} mpt_row_type;
  mpt_row_type rows [5] = '{
    '{`MPT_OFS_PRESCALE, 32'hffff_ffff, 32'hffff_ffff, 1'h0},
    '{`MPT_OFS_MATCH_BASE + 12'h018, 32'h1234_5678, 32'h1234_5678, 1'h0},
    '{`MPT_OFS_IRQ_MASK, 32'h0000_01ff, 32'h0000_01ff, 1'h0},
    '{`MPT_OFS_COUNT, 32'h0000_0005, 32'h0, 1'h0},
    '{12'h014, 32'h0000_0001, 32'h0, 1'h1}};
  // Period 10 counts; output 1 single edge falls at 3, output 3 double edge from 2 to 6
  logic [43:0] setup [9] = '{{`MPT_OFS_IRQ_MASK, 32'h0}, {`MPT_OFS_PRESCALE, 32'h0},
    {`MPT_OFS_MATCH_BASE, 32'h9}, {`MPT_OFS_MATCH_BASE + 12'h004, 32'h3},
    {`MPT_OFS_MATCH_BASE + 12'h008, 32'h2}, {`MPT_OFS_MATCH_BASE + 12'h00c, 32'h6},
    {`MPT_OFS_OUT_CTRL, 32'h288}, {`MPT_OFS_RELEASE, 32'hf}, {`MPT_OFS_CTRL, 32'h9}};
  always #4 clk = ~clk;
  mpt_top mpt_top_i (.clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cap_i(cap), .pwm_o(pwm), .irq_o(irq));
  mpt_load_model mpt_load_model_i (.clk_i(clk), .pwm_i(pwm), .hi_len(hi_len), .period(period), .rises(rises));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One APB transfer; waits on pready rather than assuming zero wait states
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      tally_and_finish();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // Watchdog far beyond the few hundred cycles the sequence needs
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    cyc(6);
    rstn <= 1'h1;
    cyc(3);
    foreach (rows[i])
    begin
      apb(1'h1, rows[i].a, rows[i].d);
      apb(1'h0, rows[i].a, 32'h0);
      check($sformatf("reg %h", rows[i].a), rv, rows[i].q);
      check("slverr", re, rows[i].e);
    end
    $display("test registers done");
    foreach (setup[i])
      apb(1'h1, setup[i][43:32], setup[i][31:0]);
    cyc(40);
    check("period out1", period[1], 32'd10);
    check("period out3", period[3], 32'd10);
    check("high out1", hi_len[1], 32'd4);
    check("high out3", hi_len[3], 32'd4);
    check("rises out2", rises[2], 32'd0);
    apb(1'h1, `MPT_OFS_MATCH_BASE + 12'h004, 32'h5);
    cyc(25);
    check("unreleased", hi_len[1], 32'd4);
    apb(1'h1, `MPT_OFS_RELEASE, 32'h2);
    cyc(25);
    check("released", hi_len[1], 32'd6);
    apb(1'h1, `MPT_OFS_MATCH_BASE + 12'h008, 32'h6);
    apb(1'h1, `MPT_OFS_MATCH_BASE + 12'h00c, 32'h2);
    apb(1'h1, `MPT_OFS_RELEASE, 32'hc);
    cyc(35);
    // Low from count 3 to 6, high across the wrap from 7 to 2
    check("reversed", hi_len[3], 32'd6);
    $display("test pwm done");
    apb(1'h1, `MPT_OFS_MATCH_ACT, 32'h1);
    apb(1'h1, `MPT_OFS_IRQ_MASK, 32'h1);
    cyc(12);
    check("irq on", irq, 1'h1);
    apb(1'h0, `MPT_OFS_IRQ_STAT, 32'h0);
    check("stat m0", rv[0], 1'h1);
    apb(1'h1, `MPT_OFS_IRQ_MASK, 32'h0);
    cyc(3);
    check("irq masked", irq, 1'h0);
    apb(1'h1, `MPT_OFS_MATCH_BASE + 12'h010, 32'h5);
    apb(1'h1, `MPT_OFS_RELEASE, 32'h10);
    apb(1'h1, `MPT_OFS_MATCH_ACT, 32'h4001);
    cyc(30);
    apb(1'h0, `MPT_OFS_CTRL, 32'h0);
    check("stopped", rv[0], 1'h0);
    apb(1'h0, `MPT_OFS_COUNT, 32'h0);
    cv = rv;
    apb(1'h1, `MPT_OFS_CAP_CTRL, 32'h5);
    cap <= 2'h1;
    cyc(10);
    apb(1'h0, `MPT_OFS_COUNT, 32'h0);
    check("frozen", rv, cv);
    apb(1'h0, `MPT_OFS_CAP0, 32'h0);
    check("capture", rv, cv);
    apb(1'h0, `MPT_OFS_IRQ_STAT, 32'h0);
    check("stat cap0", rv[7], 1'h1);
    apb(1'h1, `MPT_OFS_IRQ_STAT, 32'h80);
    apb(1'h0, `MPT_OFS_IRQ_STAT, 32'h0);
    check("w1c cap0", rv[7], 1'h0);
    cap <= 2'h0;
    $display("test events done");
    rstn <= 1'h0;
    cyc(2);
    check("pwm reset", pwm, 6'h00);
    check("irq reset", irq, 1'h0);
    rstn <= 1'h1;
    cyc(3);
    apb(1'h0, `MPT_OFS_PRESCALE, 32'h0);
    check("prescale reset", rv, `MPT_RST_ZERO);
    apb(1'h0, `MPT_OFS_CTRL, 32'h0);
    check("ctrl reset", rv, `MPT_RST_ZERO);
    $display("test reset done");
    // Counter mode: three rising edges on capture pin 0 give three counts
    apb(1'h1, `MPT_OFS_MODE, 32'h1);
    apb(1'h1, `MPT_OFS_CTRL, 32'h1);
    repeat (3)
    begin
      cap <= 2'h1;
      cyc(8);
      cap <= 2'h0;
      cyc(8);
    end
    apb(1'h0, `MPT_OFS_COUNT, 32'h0);
    check("edge count", rv, 32'h3);
    $display("test counter mode done");
    tally_and_finish();
  end
endmodule : match_based_pwm_timer_tb

// [bench/mpt_load_model.sv]
// Load model on the PWM pins: high time, period and rising edges of each output
module mpt_load_model
(
  // Clock and PWM pins
  input wire logic clk_i,
  input wire logic [6:1] pwm_i,
  // Measurements
  output int hi_len [6:1],
  output int period [6:1],
  output int rises [6:1]
);
  timeunit 1ns;
  timeprecision 1ps;
  int run [6:1];
  int since [6:1];
  logic [6:1] last = 6'h00;
  // Loads only listen; pins are sampled once a clock, so widths are in clock cycles
  always @(posedge clk_i)
  begin
    for (int n = 1; n <= 6; n++)
    begin
      if (pwm_i[n] && !last[n])
      begin
        rises[n]++;
        period[n] = since[n]; // Rise to rise
        since[n] = 0;
        run[n] = 0;
      end
      if (!pwm_i[n] && last[n])
        hi_len[n] = run[n];
      since[n]++;
      if (pwm_i[n])
        run[n]++;
    end
    last = pwm_i;
  end
endmodule : mpt_load_model

// [bench/mpt_top_asserts.sv]
// Port checks of the match based PWM timer
`include "mpt_map.svh"
module mpt_top_asserts
(
  // Observed ports
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [6:1] pwm_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  ready_in_access_a: assert property (psel_i && penable_i |-> pready_o)
    else $error("access cycle without pready");
  ready_single_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  ready_only_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access cycle");
  err_reads_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error response malformed");
  mapped_no_err_a: assert property (pready_o && paddr_i inside {`MPT_OFS_CTRL, `MPT_OFS_PRESCALE} |-> !pslverr_o)
    else $error("error on mapped register");
  hole_err_a: assert property (pready_o && paddr_i == 12'h014 |-> pslverr_o)
    else $error("no error on unmapped hole");
  mask_off_a: assert property (psel_i && penable_i && pwrite_i && paddr_i == `MPT_OFS_IRQ_MASK && pwdata_i == 32'h0
    |-> ##[1:3] !irq_o)
    else $error("irq stays high with mask clear");
  reset_idle_a: assert property ($rose(rstn_i) |-> pwm_o == 6'h00 && !irq_o)
    else $error("outputs active after reset");
  cover property ($rose(pwm_o[3]));
endmodule : mpt_top_asserts
bind mpt_top mpt_top_asserts mpt_top_asserts_i (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pwm_o(pwm_o), .irq_o(irq_o));

// [verilog/mpt_map.svh]
// Register offsets, field positions and reset values of the match based PWM timer
`ifndef MPT_MAP_SVH
`define MPT_MAP_SVH
`define MPT_OFS_IRQ_STAT 12'h000
`define MPT_OFS_CTRL 12'h004
`define MPT_OFS_COUNT 12'h008
`define MPT_OFS_PRESCALE 12'h00c
`define MPT_OFS_PRECOUNT 12'h010
`define MPT_OFS_MATCH_BASE 12'h018
`define MPT_OFS_MATCH_ACT 12'h034
`define MPT_OFS_CAP0 12'h038
`define MPT_OFS_CAP1 12'h03c
`define MPT_OFS_CAP_CTRL 12'h040
`define MPT_OFS_OUT_CTRL 12'h044
`define MPT_OFS_RELEASE 12'h048
`define MPT_OFS_IRQ_MASK 12'h04c
`define MPT_OFS_MODE 12'h050
`define MPT_CTRL_EN_BIT 0
`define MPT_CTRL_RST_BIT 1
`define MPT_CTRL_PWM_BIT 3
`define MPT_MODE_CSEL_BIT 2
`define MPT_IRQ_CAP0_BIT 7
`define MPT_IRQ_CAP1_BIT 8
`define MPT_RST_ZERO 32'h0000_0000
`endif

// [verilog/mpt_pkg.sv]
// Types shared by the match based PWM timer files
package mpt_pkg;
  typedef enum logic [1:0] {MPT_CNT_TIMER, MPT_CNT_RISE, MPT_CNT_FALL, MPT_CNT_BOTH} mpt_cnt_mode_type;
  typedef enum logic [1:0] {MPT_APB_IDLE, MPT_APB_SETUP, MPT_APB_DONE} mpt_apb_state_type;
endpackage : mpt_pkg

// [verilog/mpt_sync.sv]
// Three flip-flop input synchroniser with agreement of the last two stages
module mpt_sync
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Raw and filtered level
  input wire logic async_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // Stage chain; only s2 reads s1
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // A change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      level_o <= 1'b0;
    else if (s2_reg == s3_reg)
      level_o <= s3_reg;
  end
endmodule : mpt_sync

// [verilog/mpt_top.sv]
// Match based PWM timer: prescaler, counter, seven matches, captures, PWM outputs and APB slave
`include "mpt_map.svh"
// Summary of operation
// - Seven match registers drive six single-edge, three double-edge outputs, or a mix.
// - Cycle match register zero resets the counter and sets the shared period.
// - Single-edge outputs rise on cycle match and fall on their own match.
// - A single-edge output configured constant low stays low all cycle.
// - Double-edge outputs use two match registers, one per edge, anywhere in cycle.
// - Rise before fall gives high pulse; reversed order gives low pulse.
// - Period and width are any whole counts; all outputs share the cycle rate.
// - Per match: continue, stop or reset counter, each with optional interrupt.
// - New match values apply only after release, at the next cycle start in PWM mode, at once otherwise.
// - Timer mode counts clock; counter mode counts selected capture input transitions.
// - Without PWM mode the block is a plain 32-bit timer with 32-bit prescaler.
// - Capture input transition copies the counter into its capture register, optional interrupt.
module mpt_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Capture inputs from pins
  input wire logic [1:0] cap_i,
  // PWM outputs, index 1 to 6 used
  output logic [6:1] pwm_o,
  // Interrupt
  output logic irq_o
);
  logic rst_s1_reg;
  logic rst_n;
  logic [1:0] cap_lvl;
  logic [1:0] cap_prev_reg;
  logic [1:0] cap_rise;
  logic [1:0] cap_fall;
  logic [31:0] count_reg;
  logic [31:0] precount_reg;
  logic [31:0] prescale_reg;
  logic [31:0] shadow_reg [0:6];
  logic [31:0] match_reg [0:6];
  logic [20:0] match_act_reg;
  logic [6:0] release_reg;
  logic [5:0] cap_ctrl_reg;
  logic [3:0] mode_reg;
  logic [12:0] out_ctrl_reg;
  logic [8:0] irq_stat_reg;
  logic [8:0] irq_mask_reg;
  logic [8:0] irq_set;
  logic [1:0] ctrl_reg;
  logic pwm_mode_reg;
  logic [6:0] hit;
  logic tick;
  logic cycle_start;
  logic stop_hit;
  logic reset_hit;
  logic count_en;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic rd_err;
  logic [6:1] pwm_next;

  // Decode of a match register index from a byte address, 7 means none
  function automatic logic [2:0] match_index(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - `MPT_OFS_MATCH_BASE;
    if (addr >= `MPT_OFS_MATCH_BASE && addr < `MPT_OFS_MATCH_ACT && addr[1:0] == 2'b00)
      match_index = rel[4:2];
    else
      match_index = 3'h7;
  endfunction : match_index

  // Reset release through two flops so the release is synchronous
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // Capture pins are asynchronous and need filtering before edge detection
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cap_sync
      mpt_sync u_sync
      (
        .clk_i(clk_i),
        .rstn_i(rst_n),
        .async_i(cap_i[gi]),
        .level_o(cap_lvl[gi])
      );
    end
  endgenerate

  // Edge history of the filtered capture inputs
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      cap_prev_reg <= 2'h0;
    else
      cap_prev_reg <= cap_lvl;
  end
  assign cap_rise = cap_lvl & ~cap_prev_reg;
  assign cap_fall = ~cap_lvl & cap_prev_reg;

  // Count source: clock or selected capture edges
  always_comb
  begin
    logic src;
    logic r;
    logic f;
    src = mode_reg[`MPT_MODE_CSEL_BIT];
    r = cap_rise[src];
    f = cap_fall[src];
    case (mpt_pkg::mpt_cnt_mode_type'(mode_reg[1:0]))
      mpt_pkg::MPT_CNT_TIMER: count_en = 1'b1;
      mpt_pkg::MPT_CNT_RISE: count_en = r;
      mpt_pkg::MPT_CNT_FALL: count_en = f;
      mpt_pkg::MPT_CNT_BOTH: count_en = r | f;
      default: count_en = 1'b0;
    endcase
  end

  // Prescale terminal gives the counter step
  assign tick = ctrl_reg[`MPT_CTRL_EN_BIT] && !ctrl_reg[`MPT_CTRL_RST_BIT] && count_en
    && (precount_reg == prescale_reg);

  // Match compare on the active values
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_match
      assign hit[gi] = (count_reg == match_reg[gi]);
    end
  endgenerate

  // Match zero forces reset in PWM mode; others by their action bits
  always_comb
  begin
    stop_hit = 1'b0;
    reset_hit = tick && hit[0] && pwm_mode_reg;
    for (int i = 0; i < 7; i++)
    begin
      if (tick && hit[i] && match_act_reg[3 * i + 1])
        reset_hit = 1'b1;
      if (tick && hit[i] && match_act_reg[3 * i + 2])
        stop_hit = 1'b1;
    end
  end
  assign cycle_start = reset_hit && hit[0];

  // Prescale counter wraps to zero at its terminal value
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      precount_reg <= `MPT_RST_ZERO;
    else if (ctrl_reg[`MPT_CTRL_RST_BIT] || tick)
      precount_reg <= `MPT_RST_ZERO;
    else if (ctrl_reg[`MPT_CTRL_EN_BIT] && count_en)
      precount_reg <= precount_reg + 32'h1;
  end

  // Main 32-bit counter
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= `MPT_RST_ZERO;
    else if (ctrl_reg[`MPT_CTRL_RST_BIT] || reset_hit)
      count_reg <= `MPT_RST_ZERO;
    else if (tick && !stop_hit)
      count_reg <= count_reg + 32'h1;
  end

  // Bus strobes: write takes effect in the access phase, read in the setup phase
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;

  // Control: enable, counter reset, PWM mode; a stop match clears enable
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= 2'h0;
      pwm_mode_reg <= 1'b0;
    end
    else if (wr_en && paddr_i == `MPT_OFS_CTRL)
    begin
      ctrl_reg <= pwdata_i[1:0];
      pwm_mode_reg <= pwdata_i[`MPT_CTRL_PWM_BIT];
    end
    else if (stop_hit)
      ctrl_reg[`MPT_CTRL_EN_BIT] <= 1'b0;
  end

  // Plain configuration registers
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_reg <= `MPT_RST_ZERO;
      match_act_reg <= 21'h0;
      cap_ctrl_reg <= 6'h0;
      mode_reg <= 4'h0;
      out_ctrl_reg <= 13'h0;
      irq_mask_reg <= 9'h0;
    end
    else if (wr_en)
    begin
      case (paddr_i)
        `MPT_OFS_PRESCALE: prescale_reg <= pwdata_i;
        `MPT_OFS_MATCH_ACT: match_act_reg <= pwdata_i[20:0];
        `MPT_OFS_CAP_CTRL: cap_ctrl_reg <= pwdata_i[5:0];
        `MPT_OFS_MODE: mode_reg <= pwdata_i[3:0];
        `MPT_OFS_OUT_CTRL: out_ctrl_reg <= pwdata_i[12:0];
        `MPT_OFS_IRQ_MASK: irq_mask_reg <= pwdata_i[8:0];
        default: ;
      endcase
    end
  end

  // Shadow writes, release latch and transfer at cycle start or when PWM is off
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      release_reg <= 7'h0;
      for (int i = 0; i < 7; i++)
      begin
        shadow_reg[i] <= `MPT_RST_ZERO;
        match_reg[i] <= `MPT_RST_ZERO;
      end
    end
    else
    begin
      for (int i = 0; i < 7; i++)
      begin
        if (release_reg[i] && (cycle_start || !pwm_mode_reg))
        begin
          match_reg[i] <= shadow_reg[i];
          release_reg[i] <= 1'b0;
        end
      end
      if (wr_en && match_index(paddr_i) != 3'h7)
        shadow_reg[match_index(paddr_i)] <= pwdata_i;
      if (wr_en && paddr_i == `MPT_OFS_RELEASE)
        release_reg <= release_reg | pwdata_i[6:0];
    end
  end

  // Capture registers take the counter on the enabled edges
  logic [31:0] cap_reg [0:1];
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cap
      always_ff @(posedge clk_i or negedge rst_n)
      begin
        if (!rst_n)
          cap_reg[gi] <= `MPT_RST_ZERO;
        else if ((cap_rise[gi] && cap_ctrl_reg[3 * gi]) || (cap_fall[gi] && cap_ctrl_reg[3 * gi + 1]))
          cap_reg[gi] <= count_reg;
      end
    end
  endgenerate

  // Interrupt events: matches with interrupt enabled, and captures
  always_comb
  begin
    for (int i = 0; i < 7; i++)
      irq_set[i] = tick && hit[i] && match_act_reg[3 * i];
    irq_set[`MPT_IRQ_CAP0_BIT] = (cap_rise[0] && cap_ctrl_reg[0] || cap_fall[0] && cap_ctrl_reg[1]) && cap_ctrl_reg[2];
    irq_set[`MPT_IRQ_CAP1_BIT] = (cap_rise[1] && cap_ctrl_reg[3] || cap_fall[1] && cap_ctrl_reg[4]) && cap_ctrl_reg[5];
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_reg <= 9'h0;
    else if (wr_en && paddr_i == `MPT_OFS_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~pwdata_i[8:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end

  // Level interrupt from a flop
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_reg & irq_mask_reg);
  end

  // Output next state; out_ctrl bits 2..6 pick double edge, 7..12 enable
  always_comb
  begin
    pwm_next = pwm_o;
    for (int n = 1; n <= 6; n++)
    begin
      if (!out_ctrl_reg[n + 6])
        pwm_next[n] = 1'b0;
      else if (n >= 2 && out_ctrl_reg[n])
      begin
        // Double edge: rise on match n-1, fall on match n
        if (tick && hit[n] && pwm_mode_reg)
          pwm_next[n] = 1'b0;
        else if (tick && hit[n - 1] && pwm_mode_reg)
          pwm_next[n] = 1'b1;
        // No action at cycle start, so a fall before the rise gives a low pulse
        // with the high time wrapping over the cycle boundary
      end
      else
      begin
        // Single edge: fall wins when width equals the match, giving zero width
        if (tick && hit[n] && pwm_mode_reg)
          pwm_next[n] = 1'b0;
        else if (cycle_start)
          pwm_next[n] = 1'b1;
      end
    end
    if (!pwm_mode_reg)
      pwm_next = 6'h0;
  end

  // PWM output flops; all share the match zero cycle
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      pwm_o <= 6'h0;
    else
      pwm_o <= pwm_next;
  end

  // Read mux
  always_comb
  begin
    logic [2:0] mi;
    mi = match_index(paddr_i);
    rd_err = 1'b0;
    rd_data = 32'h0;
    if (mi != 3'h7)
      rd_data = shadow_reg[mi];
    else
    begin
      case (paddr_i)
        `MPT_OFS_IRQ_STAT: rd_data = {23'h0, irq_stat_reg};
        `MPT_OFS_CTRL: rd_data = {28'h0, pwm_mode_reg, 1'b0, ctrl_reg};
        `MPT_OFS_COUNT: rd_data = count_reg;
        `MPT_OFS_PRESCALE: rd_data = prescale_reg;
        `MPT_OFS_PRECOUNT: rd_data = precount_reg;
        `MPT_OFS_MATCH_ACT: rd_data = {11'h0, match_act_reg};
        `MPT_OFS_CAP0: rd_data = cap_reg[0];
        `MPT_OFS_CAP1: rd_data = cap_reg[1];
        `MPT_OFS_CAP_CTRL: rd_data = {26'h0, cap_ctrl_reg};
        `MPT_OFS_OUT_CTRL: rd_data = {19'h0, out_ctrl_reg};
        `MPT_OFS_RELEASE: rd_data = {25'h0, release_reg};
        `MPT_OFS_IRQ_MASK: rd_data = {23'h0, irq_mask_reg};
        `MPT_OFS_MODE: rd_data = {28'h0, mode_reg};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // APB answer: ready in every access phase, data sampled in the setup cycle
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && rd_err;
      if (rd_en)
        prdata_o <= rd_data;
    end
  end
endmodule : mpt_top
